/* File: inc/tstc_cfg.svh */
// Constants of the transport system time clock block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TSTC_CFG_SVH
`define TSTC_CFG_SVH

// Register byte offsets on the AHB-Lite slave
`define TSTC_OFF_INIT_UPPER 8'h00
`define TSTC_OFF_LOW_WORD 8'h04
`define TSTC_OFF_HIGH_WORD 8'h08
`define TSTC_OFF_CTRL 8'h0C
`define TSTC_OFF_W 8

// Field positions
`define TSTC_TOP_BIT 0
`define TSTC_EXT_LSB 1
`define TSTC_EXT_MSB 9
`define TSTC_CTRL_TS_MODE 0

// Reset values
`define TSTC_INIT_RESET 10'h000
`define TSTC_CTRL_RESET 1'h0

// Timing: bus clock and extension rate in MHz, extension count last value
`define TSTC_CLK_MHZ 8'h64
`define TSTC_EXT_MHZ 8'h1B
`define TSTC_EXT_LAST 9'h12B

// AHB transfer type bit that marks an active transfer
`define TSTC_HTRANS_ACTIVE 1

`endif

/* File: inc/tstc_pkg.sv */
// Types of the transport system time clock block.
// Assumes tstc_cfg.svh is reachable on the include path.
`include "tstc_cfg.svh"

package tstc_pkg;

	// *****************************
	// Carrier types
	// *****************************

	// Full clock value: 33-bit base plus 9-bit extension
	typedef struct packed {
		logic clock_ref_top_bit;
		logic [31:0] base_low;
		logic [8:0] clock_ref_extension;
	} tstc_value_t;

	// Captured AHB-Lite address phase
	typedef struct packed {
		logic active;
		logic write;
		logic [`TSTC_OFF_W-1:0] offset;
	} tstc_bus_req_t;

endpackage : tstc_pkg

/* File: hw/tstc_counter.sv */
// System time clock counter: 27 MHz timebase, extension modulo 300, 33-bit base.
// Assumes a 100 MHz clock and a one-cycle load pulse from the register block.
`timescale 1ns/1ps
`include "tstc_cfg.svh"

module tstc_counter
	import tstc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic load,
	input wire tstc_value_t load_value,
	output logic ext_tick,
	output tstc_value_t value
);

	// *****************************
	// 27 MHz timebase
	// *****************************

	logic [7:0] phase;
	logic [7:0] next_phase;

	// Fractional accumulator: 27 ticks per 100 bus clocks
	always_comb
	begin
		next_phase = phase + `TSTC_EXT_MHZ;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			phase <= 8'h00;
			ext_tick <= 1'b0;
		end
		else if (next_phase >= `TSTC_CLK_MHZ)
		begin
			phase <= next_phase - `TSTC_CLK_MHZ;
			ext_tick <= 1'b1;
		end
		else
		begin
			phase <= next_phase;
			ext_tick <= 1'b0;
		end
	end

	// *****************************
	// Extension and base count
	// *****************************

	always_ff @(posedge clock)
	begin
		if (rst)
			value <= '0;
		else if (load)
			value <= load_value;
		else if (run && ext_tick)
		begin
			if (value.clock_ref_extension == `TSTC_EXT_LAST)
			begin
				value.clock_ref_extension <= 9'h000;
				// Top bit toggles only on the low-word carry
				{value.clock_ref_top_bit, value.base_low} <=
					{value.clock_ref_top_bit, value.base_low} + 33'h000000001;
			end
			else
				value.clock_ref_extension <= value.clock_ref_extension + 9'h001;
		end
	end

endmodule : tstc_counter

/* File: hw/tstc_top.sv */
// Transport system time clock with its AHB-Lite register slave.
// Assumes one 100 MHz bus clock, synchronous active-high reset, word accesses.
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tstc_cfg.svh"

module tstc_top
	import tstc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	// *****************************
	// Declarations
	// *****************************

	tstc_bus_req_t data_phase;
	tstc_value_t value;
	tstc_value_t load_value;
	logic [9:0] init_upper;
	logic [9:0] next_init_upper;
	logic ts_mode;
	logic next_ts_mode;
	logic addr_take;
	logic write_init;
	logic write_low;
	logic write_ctrl;
	logic load;
	logic ext_tick;

	// Offset match used by write and read decode
	function automatic logic is_offset(input logic [`TSTC_OFF_W-1:0] offset,
		input logic [`TSTC_OFF_W-1:0] target);
		is_offset = (offset == target);
	endfunction : is_offset

	// *****************************
	// AHB-Lite address phase
	// *****************************

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_take = hsel && htrans[`TSTC_HTRANS_ACTIVE] && hready;

	always_ff @(posedge clock)
	begin
		if (rst)
			data_phase <= '0;
		else if (hready)
		begin
			data_phase.active <= addr_take;
			data_phase.write <= hwrite;
			data_phase.offset <= haddr[`TSTC_OFF_W-1:0];
		end
	end

	// *****************************
	// Write decode
	// *****************************

	assign write_init = data_phase.active && data_phase.write &&
		is_offset(data_phase.offset, `TSTC_OFF_INIT_UPPER);
	assign write_low = data_phase.active && data_phase.write &&
		is_offset(data_phase.offset, `TSTC_OFF_LOW_WORD);
	assign write_ctrl = data_phase.active && data_phase.write &&
		is_offset(data_phase.offset, `TSTC_OFF_CTRL);

	// Load only takes effect in transport stream mode
	assign load = write_low && ts_mode;

	// Forwarded values so a read right after a write sees the new data
	always_comb
	begin
		next_init_upper = init_upper;
		next_ts_mode = ts_mode;
		if (write_init)
			next_init_upper = hwdata[`TSTC_EXT_MSB:`TSTC_TOP_BIT];
		if (write_ctrl)
			next_ts_mode = hwdata[`TSTC_CTRL_TS_MODE];
	end

	// *****************************
	// Registers
	// *****************************

	always_ff @(posedge clock)
	begin
		if (rst)
			init_upper <= `TSTC_INIT_RESET;
		else
			init_upper <= next_init_upper;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			ts_mode <= `TSTC_CTRL_RESET;
		else
			ts_mode <= next_ts_mode;
	end

	// Low word from the bus, upper part from the init register
	always_comb
	begin
		load_value.base_low = hwdata;
		load_value.clock_ref_top_bit = init_upper[`TSTC_TOP_BIT];
		load_value.clock_ref_extension = init_upper[`TSTC_EXT_MSB:`TSTC_EXT_LSB];
	end

	// *****************************
	// Counter
	// *****************************

	tstc_counter u_counter (
		.clock(clock),
		.rst(rst),
		.run(ts_mode),
		.load(load),
		.load_value(load_value),
		.ext_tick(ext_tick),
		.value(value)
	);

	// *****************************
	// Read data
	// *****************************

	// Sampled at the address phase, presented in the data phase
	always_ff @(posedge clock)
	begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (addr_take && !hwrite)
		begin
			if (is_offset(haddr[`TSTC_OFF_W-1:0], `TSTC_OFF_INIT_UPPER))
				hrdata <= {22'h000000, next_init_upper};
			else if (is_offset(haddr[`TSTC_OFF_W-1:0], `TSTC_OFF_LOW_WORD))
				hrdata <= value.base_low;
			else if (is_offset(haddr[`TSTC_OFF_W-1:0], `TSTC_OFF_HIGH_WORD))
				hrdata <= {22'h000000, value.clock_ref_extension,
					value.clock_ref_top_bit};
			else if (is_offset(haddr[`TSTC_OFF_W-1:0], `TSTC_OFF_CTRL))
				hrdata <= {31'h00000000, next_ts_mode};
			else
				hrdata <= 32'h00000000;
		end
	end

	// *****************************
	// Assertions
	// *****************************

	load_top_bit_a: assert property (@(posedge clock) disable iff (rst)
		load |=> value.clock_ref_top_bit == $past(init_upper[`TSTC_TOP_BIT]))
		else $error("base top bit not loaded from init register");

	load_extension_a: assert property (@(posedge clock) disable iff (rst)
		load |=> value.clock_ref_extension == $past(init_upper[`TSTC_EXT_MSB:`TSTC_EXT_LSB]))
		else $error("extension not loaded from init register");

	low_word_read_a: assert property (@(posedge clock) disable iff (rst)
		(addr_take && !hwrite && haddr[`TSTC_OFF_W-1:0] == `TSTC_OFF_LOW_WORD)
		|=> hrdata == $past(value.base_low))
		else $error("low word read does not show the base count");

	high_word_read_a: assert property (@(posedge clock) disable iff (rst)
		(addr_take && !hwrite && haddr[`TSTC_OFF_W-1:0] == `TSTC_OFF_HIGH_WORD)
		|=> hrdata == {22'h000000, $past(value.clock_ref_extension),
			$past(value.clock_ref_top_bit)})
		else $error("high word read does not show top bit and extension");

	base_step_a: assert property (@(posedge clock) disable iff (rst)
		(!load && !(ts_mode && ext_tick && value.clock_ref_extension == `TSTC_EXT_LAST))
		|=> $stable({value.clock_ref_top_bit, value.base_low}))
		else $error("base count moved without an extension wrap");

	ext_wrap_a: assert property (@(posedge clock) disable iff (rst)
		(!load && ts_mode && ext_tick && value.clock_ref_extension == `TSTC_EXT_LAST)
		|=> value.clock_ref_extension == 9'h000
		&& value.base_low == $past(value.base_low) + 32'h00000001)
		else $error("extension wrap did not advance the base");

	ext_step_a: assert property (@(posedge clock) disable iff (rst)
		(!load && ts_mode && ext_tick && value.clock_ref_extension != `TSTC_EXT_LAST)
		|=> value.clock_ref_extension == $past(value.clock_ref_extension) + 9'h001)
		else $error("extension did not step on the timebase tick");

	tick_spacing_a: assert property (@(posedge clock) disable iff (rst)
		ext_tick |=> !ext_tick ##1 !ext_tick[*1])
		else $error("timebase ticks closer than the 27 MHz spacing");

	top_bit_toggle_a: assert property (@(posedge clock) disable iff (rst)
		(!load && $past(value.base_low) != 32'hFFFFFFFF && !$past(load))
		|-> $stable(value.clock_ref_top_bit))
		else $error("base top bit changed without a low-word wrap");

	ext_range_a: assert property (@(posedge clock) disable iff (rst)
		(!load && value.clock_ref_extension <= `TSTC_EXT_LAST)
		|=> value.clock_ref_extension <= `TSTC_EXT_LAST)
		else $error("extension left its modulo 300 range");

	idle_hold_a: assert property (@(posedge clock) disable iff (rst)
		(!ts_mode && !load) |=> $stable(value))
		else $error("counter moved outside transport stream mode");

endmodule : tstc_top

/* File: tb/transport_system_time_clock_test.sv */
// Self-checking bench for the system time clock with its AHB-Lite register slave.
// Assumes tstc_top with zero wait states; hready is looped back from hreadyout.
`timescale 1ns/1ps

module transport_system_time_clock_test;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	int errors = 0;
	int num_checks = 0;
	logic [31:0] r1;
	logic [31:0] r2;

	assign hready = hreadyout;
	always #5 clock = ~clock;

	tstc_top u_tstc_top (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

	// ************************
	// Bus and check tasks
	// ************************
	task end_of_test;
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1)
		begin
			errors++;
			end_of_test;
		end
	endtask : wait_ready

	task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask : chk

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		q = hrdata;
		chk({31'h00000000, hresp}, 32'h0, 32'h0);
	endtask : bus

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rd(input logic [31:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask : rd

	// ************************
	// Scenarios
	// ************************
	task reset_and_map;
		logic [31:0] q;
		for (int i = 0; i < 5; i++)
		begin
			rd(32'h4 * i, q);
			chk(q, 32'h0, 32'h0);
		end
		wr(32'h00, 32'hFFFFFFFF);
		rd(32'h00, q);
		chk(q, 32'h3FF, 32'h3FF);
		wr(32'h00, 32'h0);
	endtask : reset_and_map

	task load_top_bit;
		wr(32'h0C, 32'h1);
		wr(32'h00, 32'h1);
		wr(32'h04, 32'h12345678);
		wr(32'h0C, 32'h0);
		rd(32'h04, r1);
		chk(r1, 32'h12345678, 32'h12345678);
		rd(32'h08, r2);
		chk(r2 & 32'h1, 32'h1, 32'h1);
		chk(r2 >> 1, 32'h0, 32'h1);
	endtask : load_top_bit

	task wrap_carry;
		wr(32'h0C, 32'h1);
		wr(32'h00, 32'h256);
		wr(32'h04, 32'hFFFFFFFF);
		repeat (20) @(posedge clock);
		wr(32'h0C, 32'h0);
		rd(32'h04, r1);
		chk(r1, 32'h0, 32'h0);
		rd(32'h08, r2);
		chk(r2 & 32'h1, 32'h1, 32'h1);
		chk(r2 >> 1, 32'h3, 32'h8);
	endtask : wrap_carry

	task rate_and_hold;
		logic [31:0] q;
		wr(32'h00, 32'h0);
		wr(32'h0C, 32'h1);
		wr(32'h04, 32'h0);
		repeat (2990) @(posedge clock);
		rd(32'h04, r1);
		rd(32'h04, r2);
		chk(r2 - r1, 32'h0, 32'h1);
		wr(32'h0C, 32'h0);
		rd(32'h04, r1);
		chk(r1, 32'h2, 32'h2);
		rd(32'h08, r2);
		chk(r2, 32'h1A0, 32'h1AC);
		wr(32'h04, 32'hAAAA5555);
		wr(32'h08, 32'h3FF);
		rd(32'h04, q);
		chk(q, r1, r1);
		rd(32'h08, q);
		chk(q, r2, r2);
	endtask : rate_and_hold

	// ************************
	// Main sequence
	// ************************
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		reset_and_map;
		load_top_bit;
		wrap_carry;
		rate_and_hold;
		end_of_test;
	end
endmodule : transport_system_time_clock_test
